// ### pmx_pin_cfg.sv
// Purpose: Drive level, port supply, pin function and direction registers
// Assumes: Single clock, synchronous active-high reset, plain register port
// Notes: Pin outputs follow the registers with one cycle of latency
//
// Summary of operation
// - Two-bit drive field: level 0 to 3
// - Register 0 fields: ports A and B
// - Register 1 fields: ports C and D
// - Register 2 fields: ports E and F
// - Register 3: G, J; top bits zero
// - Supply upper bit picks aux supply
// - Supply register bits 7..2 read zero
// - Aux needs PE4 function and 1x
// - Supply only for digital pins, except reset
// - Output selects per port, input routes
// - Drive level acts only on push-pull
// - Direction resets to one, input
`timescale 1ns/1ps
`include "pmx_defs.svh"

module pmx_pin_cfg
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire pmx_pkg::pmx_bus_s bus_i,
   output logic [7:0] rdata_o,
   input wire logic [3:0] pe_digital_i,
   output pmx_pkg::pmx_pin_s [63:0] pin_o,
   output logic [3:0] pe_aux_supply_o,
   output logic rst_dbg_aux_o,
   output logic [14:0][7:0] out_sel_o,
   output logic [3:0][7:0] in_route_o,
   output logic [7:0][7:0] dir_o
);
   import pmx_pkg::*;

   // ==========================================================
   // Decode helpers
   pmx_byte_t regs [`PMX_REG_CNT];
   logic mapped;
   logic [4:0] idx;

   function automatic pmx_byte_t reg_mask(input logic [4:0] i);
      pmx_byte_t m;
      m = `PMX_MASK_FULL;
      case (i)
         `PMX_DRV3: m = `PMX_MASK_DRV3;
         `PMX_SUPPLY: m = `PMX_MASK_SUPPLY;
         `PMX_OSEL_D1: m = `PMX_MASK_OSEL_D1;
         `PMX_OSEL_J0: m = `PMX_MASK_OSEL_J0;
         `PMX_ISEL_TCK: m = `PMX_MASK_ISEL_TCK;
         `PMX_ISEL_SER: m = `PMX_MASK_ISEL_SER;
         `PMX_ISEL_RX: m = `PMX_MASK_ISEL_RX;
         `PMX_DIR_D: m = `PMX_MASK_DIR_D;
         `PMX_DIR_J: m = `PMX_MASK_DIR_J;
         default: m = `PMX_MASK_FULL;
      endcase
      return m;
   endfunction

   function automatic pmx_byte_t reg_reset(input logic [4:0] i);
      pmx_byte_t r;
      r = `PMX_CFG_RST;
      if (i >= `PMX_DIR_BASE)
      begin
         r = `PMX_DIR_RST & reg_mask(i);
      end
      return r;
   endfunction

   assign idx = bus_i.addr[4:0];
   assign mapped = (bus_i.addr[7:5] == 3'h0);

   // ==========================================================
   // Register writes
   // Masking on write keeps missing bits at zero for all readers
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < `PMX_REG_CNT; i++)
         begin
            regs[i] <= reg_reset(5'(i));
         end
      end
      else if (bus_i.wr && mapped)
      begin
         regs[idx] <= bus_i.wdata & reg_mask(idx);
      end
   end

   // ==========================================================
   // Register reads
   // Data stands for one cycle only; unmapped reads give zero
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         rdata_o <= 8'h00;
      end
      else if (bus_i.rd && mapped)
      begin
         rdata_o <= regs[idx] & reg_mask(idx);
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end

   // ==========================================================
   // Function selects and input routes
   genvar s;
   generate
      for (s = 0; s < 15; s++)
      begin : g_osel
         assign out_sel_o[s] = regs[`PMX_OSEL_BASE + 5'(s)];
      end
      for (s = 0; s < 4; s++)
      begin : g_isel
         assign in_route_o[s] = regs[`PMX_ISEL_BASE + 5'(s)];
      end
      for (s = 0; s < 8; s++)
      begin : g_dir
         assign dir_o[s] = regs[`PMX_DIR_BASE + 5'(s)];
      end
   endgenerate

   // ==========================================================
   // Per-pin drive level
   // Ports A..G then J; each drive register covers two ports
   genvar g;
   pmx_pin_s [63:0] next_pin;
   generate
      for (g = 0; g < 64; g++)
      begin : g_pin
         localparam int PORT = g / 8;
         localparam int PIN = g % 8;
         localparam logic [4:0] DRV_IDX =
            `PMX_DRV_BASE + 5'(PORT / 2);
         localparam logic [4:0] DIR_IDX =
            `PMX_DIR_BASE + 5'(PORT);
         localparam int POS = ((PORT % 2) * 2 + PIN / 4) * 2;
         pmx_byte_t vmask;
         logic valid;
         logic next_pp;

         // Missing pins (D7, J2..J7) are never push-pull
         assign vmask = reg_mask(DIR_IDX);
         assign valid = vmask[PIN];
         assign next_pp = valid & ~regs[DIR_IDX][PIN];
         assign next_pin[g].push_pull = next_pp;
         assign next_pin[g].drive = next_pp ? regs[DRV_IDX][POS +: 2]
                                            : 2'h0;
      end
   endgenerate

   // One register for all pins keeps a single driver on the port
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         pin_o <= '0;
      end
      else
      begin
         pin_o <= next_pin;
      end
   end

   // ==========================================================
   // Port E low-nibble supply
   logic aux_sel;

   // Lower field bit is a don't-care; port E pin 4 must carry aux input
   assign aux_sel = regs[`PMX_SUPPLY][`PMX_SUPPLY_SRC_BIT] &&
      (regs[`PMX_OSEL_E1][`PMX_PORT_E_PIN4_LSB +: 2] ==
       `PMX_PORT_E_PIN4_AUX_CODE);

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         pe_aux_supply_o <= 4'h0;
         rst_dbg_aux_o <= 1'b0;
      end
      else
      begin
         pe_aux_supply_o <= {4{aux_sel}} & pe_digital_i;
         rst_dbg_aux_o <= aux_sel;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   chk_drv_pa_low: assert property (
      pin_o[0].push_pull |-> pin_o[0].drive == $past(regs[0][1:0]))
      else $error("PA0 drive not from bits 1..0");

   chk_drv_pb_high: assert property (
      pin_o[15].push_pull |-> pin_o[15].drive == $past(regs[0][7:6]))
      else $error("PB7 drive not from bits 7..6");

   chk_drv_pc_pd: assert property (
      (pin_o[30].push_pull |-> pin_o[30].drive == $past(regs[1][7:6]))
      and (pin_o[16].push_pull |->
           pin_o[16].drive == $past(regs[1][1:0])))
      else $error("Port C or D drive field wrong");

   chk_drv_pe_pf: assert property (
      (pin_o[44].push_pull |-> pin_o[44].drive == $past(regs[2][7:6]))
      and (pin_o[35].push_pull |->
           pin_o[35].drive == $past(regs[2][1:0])))
      else $error("Port E or F drive field wrong");

   chk_drv_pj_field: assert property (
      pin_o[57].push_pull |-> pin_o[57].drive == $past(regs[3][5:4]))
      else $error("PJ1 drive not from bits 5..4");

   chk_max_level: assert property (
      bus_i.wr && bus_i.addr == 8'h00 && bus_i.wdata[1:0] == 2'h3
      ##1 !bus_i.wr [*2] ##0 pin_o[0].push_pull |->
      pin_o[0].drive == 2'h3)
      else $error("Level 3 code did not reach the pin");

   chk_drv3_rsvd: assert property (
      bus_i.rd && bus_i.addr == 8'h03 |=> rdata_o[7:6] == 2'h0)
      else $error("Drive register 3 top bits not zero");

   chk_supply_rsvd: assert property (
      bus_i.rd && bus_i.addr == 8'h04 |=> rdata_o[7:2] == 6'h00)
      else $error("Supply register top bits not zero");

   chk_unmapped_zero: assert property (
      bus_i.rd && bus_i.addr[7:5] != 3'h0 |=> rdata_o == 8'h00)
      else $error("Unmapped read returned nonzero");

   chk_aux_select: assert property (
      rst_dbg_aux_o == $past(regs[4][1] && regs[14][1:0] == 2'h3))
      else $error("Aux supply selection mismatch");

   chk_aux_digital: assert property (
      pe_aux_supply_o == ({4{rst_dbg_aux_o}} & $past(pe_digital_i)))
      else $error("Aux supply reached a non-digital pin");

   chk_no_drive_input: assert property (
      !pin_o[20].push_pull |-> pin_o[20].drive == 2'h0)
      else $error("Drive level on a non push-pull pin");

   chk_dir_reset: assert property (
      $past(rst_i) |-> dir_o[0] == 8'hff && !pin_o[7].push_pull)
      else $error("Direction did not reset to input");

   chk_osel_write: assert property (
      bus_i.wr && bus_i.addr == 8'h05 |=> out_sel_o[0] ==
      $past(bus_i.wdata))
      else $error("Output select write not stored");

   // ==========================================================
   // Remaining drive fields, one pin per field

   chk_drv_pa_high: assert property (
      pin_o[4].push_pull |-> pin_o[4].drive == $past(regs[0][3:2]))
      else $error("PA4 drive not from bits 3..2");

   chk_drv_pb_low: assert property (
      pin_o[8].push_pull |-> pin_o[8].drive == $past(regs[0][5:4]))
      else $error("PB0 drive not from bits 5..4");

   chk_drv_pc_high: assert property (
      pin_o[20].push_pull |-> pin_o[20].drive == $past(regs[1][3:2]))
      else $error("PC4 drive not from bits 3..2");

   chk_drv_pd_low: assert property (
      pin_o[24].push_pull |-> pin_o[24].drive == $past(regs[1][5:4]))
      else $error("PD0 drive not from bits 5..4");

   chk_drv_pe_high: assert property (
      pin_o[36].push_pull |-> pin_o[36].drive == $past(regs[2][3:2]))
      else $error("PE4 drive not from bits 3..2");

   chk_drv_pf_low: assert property (
      pin_o[40].push_pull |-> pin_o[40].drive == $past(regs[2][5:4]))
      else $error("PF0 drive not from bits 5..4");

   chk_drv_pg_pins: assert property (
      (pin_o[48].push_pull |-> pin_o[48].drive == $past(regs[3][1:0]))
      and (pin_o[52].push_pull |->
           pin_o[52].drive == $past(regs[3][3:2])))
      else $error("Port G drive field wrong");

   chk_level_zero: assert property (
      bus_i.wr && bus_i.addr == 8'h00 && bus_i.wdata[1:0] == 2'h0
      ##1 !bus_i.wr [*2] ##0 pin_o[0].push_pull |->
      pin_o[0].drive == 2'h0)
      else $error("Level 0 code did not reach the pin");

   // ==========================================================
   // Direction, missing pins and masked writes

   chk_pp_from_dir: assert property (
      pin_o[0].push_pull == !$past(regs[24][0]))
      else $error("Push-pull does not follow direction bit");

   chk_pp_port_j: assert property (
      pin_o[56].push_pull == !$past(regs[31][0]))
      else $error("Port J push-pull does not follow direction");

   chk_missing_pins: assert property (
      !pin_o[31].push_pull && !pin_o[58].push_pull &&
      !pin_o[63].push_pull)
      else $error("A missing pin became push-pull");

   chk_wr_ignore_rsvd: assert property (
      bus_i.wr && bus_i.addr == 8'h03 |=> regs[3][7:6] == 2'h0)
      else $error("Unimplemented drive bits were stored");

   chk_osel_j_mask: assert property (
      bus_i.wr && bus_i.addr == 8'h13 |=> out_sel_o[14][7:4] == 4'h0)
      else $error("Port J select kept unimplemented bits");

   chk_in_route_wr: assert property (
      bus_i.wr && bus_i.addr == 8'h14 |=> in_route_o[0] ==
      ($past(bus_i.wdata) & 8'h7f))
      else $error("Input route write not stored");

   chk_dir_wr: assert property (
      bus_i.wr && bus_i.addr == 8'h1f |=> dir_o[7] ==
      ($past(bus_i.wdata) & 8'h03))
      else $error("Port J direction write not stored");

   // ==========================================================
   // Supply selection, read timing and the PE0 drive field

   chk_supply_rd_back: assert property (
      bus_i.rd && bus_i.addr == 8'h04 |=> rdata_o ==
      {6'h00, $past(regs[4][1:0])})
      else $error("Supply register read back wrong");

   chk_aux_upper_bit: assert property (
      rst_dbg_aux_o |-> $past(regs[4][1]))
      else $error("Aux supply without upper select bit");

   chk_aux_needs_pin4: assert property (
      rst_dbg_aux_o |-> $past(regs[14][1:0]) == 2'h3)
      else $error("Aux supply without pin 4 aux function");

   chk_rdata_stands: assert property (
      rdata_o != 8'h00 |-> $past(bus_i.rd))
      else $error("Read data outside the read answer cycle");

   chk_drv_pe_low: assert property (
      pin_o[32].push_pull |-> pin_o[32].drive == $past(regs[2][1:0]))
      else $error("PE0 drive not from bits 1..0");

   // ==========================================================
   // Covers for the main scenarios
   cov_aux_on: cover property (rst_dbg_aux_o && pe_aux_supply_o != 4'h0);
   cov_aux_blocked: cover property (regs[4][1] && !rst_dbg_aux_o);
   cov_max_drive: cover property (pin_o[8].push_pull &&
      pin_o[8].drive == 2'h3);
   cov_unmapped_rd: cover property (bus_i.rd && bus_i.addr[7:5] != 3'h0);
   cov_back_to_back: cover property (bus_i.wr ##1 bus_i.rd);
endmodule

// ### pmx_defs.svh
// Purpose: Register indices, field positions, masks and reset values
// Assumes: Eight-bit registers, one per word index on the register port
// Notes: Indices are dense from zero; anything at 32 or above is unmapped
`ifndef PMX_DEFS_SVH
`define PMX_DEFS_SVH

// ==========================================================
// Register indices
`define PMX_REG_CNT 32
`define PMX_DRV_BASE 5'h00
`define PMX_DRV3 5'h03
`define PMX_SUPPLY 5'h04
`define PMX_OSEL_BASE 5'h05
`define PMX_OSEL_D1 5'h0c
`define PMX_OSEL_E1 5'h0e
`define PMX_OSEL_J0 5'h13
`define PMX_ISEL_BASE 5'h14
`define PMX_ISEL_TCK 5'h14
`define PMX_ISEL_SER 5'h15
`define PMX_ISEL_RX 5'h17
`define PMX_DIR_BASE 5'h18
`define PMX_DIR_D 5'h1b
`define PMX_DIR_J 5'h1f

// ==========================================================
// Implemented-bit masks
`define PMX_MASK_FULL 8'hff
`define PMX_MASK_DRV3 8'h3f
`define PMX_MASK_SUPPLY 8'h03
`define PMX_MASK_OSEL_D1 8'h3f
`define PMX_MASK_OSEL_J0 8'h0f
`define PMX_MASK_ISEL_TCK 8'h7f
`define PMX_MASK_ISEL_SER 8'h7f
`define PMX_MASK_ISEL_RX 8'h03
`define PMX_MASK_DIR_D 8'h7f
`define PMX_MASK_DIR_J 8'h03

// ==========================================================
// Reset values and field positions
`define PMX_CFG_RST 8'h00
`define PMX_DIR_RST 8'hff
`define PMX_SUPPLY_SRC_BIT 1
`define PMX_PORT_E_PIN4_LSB 0
`define PMX_PORT_E_PIN4_AUX_CODE 2'h3

`endif

// ### pmx_pkg.sv
// Purpose: Types shared by the pin configuration block
// Assumes: Nothing beyond the defs header
// Notes: Each cycle that a bus strobe is high counts as one transfer
package pmx_pkg;
   typedef logic [7:0] pmx_byte_t;
   typedef logic [1:0] pmx_lvl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pmx_bus_s;

   typedef struct packed {
      logic push_pull;
      pmx_lvl_t drive;
   } pmx_pin_s;
endpackage

// ### io_drive_power_pinmux_config_test.sv
// Purpose: Self-checking bench for the pin configuration registers
// Assumes: Read data one cycle after the strobe, pins two after a write
// Notes: Expected read data is queued as each read is issued
`timescale 1ns/1ps

module io_drive_power_pinmux_config_test;
   import pmx_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   pmx_bus_s bus = '0;
   logic [3:0] pe_digital_i = 4'h0;
   logic [7:0] rdata_o;
   pmx_pin_s [63:0] pin_o;
   logic [3:0] pe_aux_supply_o;
   logic rst_dbg_aux_o;
   logic [14:0][7:0] out_sel_o;
   logic [3:0][7:0] in_route_o;
   logic [7:0][7:0] dir_o;
   logic [7:0] exp_q[$];
   logic [7:0] shadow [32];
   logic rd_q = 1'b0;
   logic [31:0] rng = 32'h0000_004a;
   int errors = 0;
   int compares = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   pmx_pin_cfg i_dut
   (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .bus_i(bus),
      .rdata_o(rdata_o),
      .pe_digital_i(pe_digital_i),
      .pin_o(pin_o),
      .pe_aux_supply_o(pe_aux_supply_o),
      .rst_dbg_aux_o(rst_dbg_aux_o),
      .out_sel_o(out_sel_o),
      .in_route_o(in_route_o),
      .dir_o(dir_o)
   );

   // ==========================================================
   // Helpers
   function automatic logic [7:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng[7:0];
   endfunction

   // Unmapped indices get mask zero, so they read as zero
   function automatic logic [7:0] msk(input int i);
      case (i)
         3, 12: return 8'h3f;
         4, 23, 31: return 8'h03;
         19: return 8'h0f;
         20, 21, 27: return 8'h7f;
         default: return (i < 32) ? 8'hff : 8'h00;
      endcase
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      if (errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Strobes stay up between ops so no signal is set twice per step
   task automatic wr(input int a, input logic [7:0] d);
      bus <= '{a[7:0], d, 1'b1, 1'b0};
      if (a < 32)
         shadow[a] = d & msk(a);
      @(posedge clk_sys_i);
   endtask

   task automatic rd(input int a);
      bus <= '{a[7:0], 8'h00, 1'b0, 1'b1};
      exp_q.push_back(a < 32 ? shadow[a] : 8'h00);
      @(posedge clk_sys_i);
   endtask

   task automatic idle(input int n);
      bus <= '0;
      repeat (n) @(posedge clk_sys_i);
   endtask

   task automatic reset_regs();
      for (int i = 0; i < 32; i++)
         shadow[i] = (i < 24) ? 8'h00 : msk(i);
   endtask

   task automatic chk_outs();
      int p;
      int b;
      int f;
      logic pp;
      @(negedge clk_sys_i);
      for (int i = 5; i < 32; i++)
         chk(i < 20 ? out_sel_o[i - 5] : i < 24 ? in_route_o[i - 20] :
            dir_o[i - 24], shadow[i]);
      for (int i = 0; i < 64; i++)
      begin
         p = i / 8;
         b = i % 8;
         f = (p % 2) * 2 + b / 4;
         pp = (i != 31) && (i < 58) && !shadow[24 + p][b];
         chk({5'h00, pin_o[i]}, {5'h00, pp,
            pp ? shadow[p / 2][2 * f +: 2] : 2'h0});
      end
      @(posedge clk_sys_i);
   endtask

   // ==========================================================
   // Read data monitor
   always @(posedge clk_sys_i)
      rd_q <= bus.rd;

   always @(negedge clk_sys_i)
   begin
      if (rd_q)
         chk(rdata_o, exp_q.pop_front());
      else if (!rst_i)
         chk(rdata_o, 8'h00);
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      logic [7:0] v;
      logic [1:0] code;
      reset_regs();
      repeat (16) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      for (int i = 0; i < 34; i++)
         rd(i == 33 ? 255 : i);
      for (int i = 0; i < 34; i++)
      begin
         wr(i == 33 ? 255 : i, rnd());
         rd(i == 33 ? 255 : i);
      end
      idle(2);
      chk_outs();
      repeat (8)
      begin
         for (int i = 0; i < 4; i++)
            wr(i, rnd());
         for (int i = 24; i < 32; i++)
            wr(i, rnd());
         idle(2);
         chk_outs();
      end
      for (int k = 0; k < 8; k++)
      begin
         code = k[2] ? 2'h3 : (k[0] ? 2'h2 : 2'h1);
         v = rnd();
         wr(4, {v[7:2], k[1:0]});
         wr(14, {v[7:2], code});
         pe_digital_i <= v[3:0];
         idle(2);
         @(negedge clk_sys_i);
         chk({7'h00, rst_dbg_aux_o}, {7'h00, k[1] & k[2]});
         chk({4'h0, pe_aux_supply_o},
            (k[1] && k[2]) ? {4'h0, v[3:0]} : 8'h00);
         @(posedge clk_sys_i);
      end
      // Select first, then make the pin an input, deselect last
      wr(5, 8'h40);
      wr(24, 8'hff);
      idle(2);
      chk_outs();
      wr(5, 8'h00);
      idle(2);
      chk_outs();
      // Second reset in mid-run must restore every register
      rst_i <= 1'b1;
      idle(2);
      rst_i <= 1'b0;
      reset_regs();
      @(posedge clk_sys_i);
      for (int i = 0; i < 32; i++)
         rd(i);
      idle(3);
      chk_outs();
      results();
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys_i);
      errors++;
      results();
   end
endmodule
